// [hw/afe_ctl.sv]
// digital mode control of a ccd front end: phases, modes, power, outputs, reset
// assumes sample and converter clocks arrive asynchronously on pins
`timescale 1ns/100ps
module afe_ctl (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_reset_pin,
    input wire logic i_sample_black_clock,
    input wire logic i_sample_pixel_clock,
    input wire logic i_converter_clock,
    input wire logic i_clamp,
    input wire logic i_power_down_pin,
    input wire logic i_output_drive_enable,
    input wire logic [11:0] i_conv_data,
    input wire logic i_conv_over,
    input wire logic i_cal_step_valid,
    input wire logic i_cal_step_up,
    input wire logic [5:0] i_addr,
    input wire logic [9:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [9:0] o_rdata,
    output afe_ctl_pkg::phase_t o_phase,
    output afe_ctl_pkg::analog_ctl_t o_analog,
    output logic [9:0] o_gain_db_x768,
    output logic [8:0] o_coarse_code,
    output logic [9:0] o_fine_code,
    output logic [11:0] o_output_bus,
    output logic [11:0] o_output_bus_oe,
    output logic o_range_exceeded_flag,
    output logic o_range_exceeded_oe
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sample_black_clock_sync;
        logic [2:0] sample_pixel_clock_sync;
        logic [2:0] aclk_sync;
        logic [2:0] clamp_sync;
        logic [2:0] pd_sync;
        logic [2:0] oe_sync;
        logic sample_black_clock;
        logic sample_pixel_clock;
        logic aclk;
        logic clamp;
        logic pd_pin;
        logic oe_pin;
        logic [9:0] gain;
        logic [9:0] control;
        logic [9:0] cal;
        logic [8:0] coarse;
        logic [9:0] fine;
        logic soft_reset;
        logic [9:0] rdata;
        // six whole sampling edges, the half added on release
        logic [afe_ctl_pkg::LATENCY_WHOLE:0][12:0] pipe;
        logic [12:0] out;
    } state_t;

    state_t state_r;
    state_t state_nxt;
    logic [2:0] rst_sync_r;
    logic chip_rst_n;
    logic soft_pulse_r;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic agree(input logic [2:0] s, input logic prev);
        agree = (s[2] == s[1]) ? s[2] : prev;
    endfunction

    // gain in twelfths of a dB: code*36/64 below saturation
    function automatic logic [9:0] gain_scaled(input logic [9:0] code);
        logic [15:0] prod;
        prod = 16'h0000;
        if (code >= afe_ctl_pkg::GAIN_SAT_CODE) begin
            gain_scaled = afe_ctl_pkg::GAIN_MAX_DB;
        end else begin
            prod = 16'(code) * 16'h0024;
            gain_scaled = prod[15:6];
        end
    endfunction

    // ------------------------------------------------------------
    // chip reset: power-on, pin and register pulse merged
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync_r <= 3'h0;
        end else if (i_reset_pin || soft_pulse_r) begin
            rst_sync_r <= 3'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[1:0], 1'b1};
        end
    end

    assign chip_rst_n = rst_sync_r[2];

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            soft_pulse_r <= 1'b0;
        end else begin
            soft_pulse_r <= state_r.soft_reset;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic power_down;
    logic cal_hold;
    logic drive_on;

    always_comb begin
        state_nxt = state_r;
        state_nxt.sample_black_clock_sync = {state_r.sample_black_clock_sync[1:0], i_sample_black_clock};
        state_nxt.sample_pixel_clock_sync = {state_r.sample_pixel_clock_sync[1:0], i_sample_pixel_clock};
        state_nxt.aclk_sync = {state_r.aclk_sync[1:0], i_converter_clock};
        state_nxt.clamp_sync = {state_r.clamp_sync[1:0], i_clamp};
        state_nxt.pd_sync = {state_r.pd_sync[1:0], i_power_down_pin};
        state_nxt.oe_sync = {state_r.oe_sync[1:0], i_output_drive_enable};
        state_nxt.sample_black_clock = agree(state_r.sample_black_clock_sync, state_r.sample_black_clock);
        state_nxt.sample_pixel_clock = agree(state_r.sample_pixel_clock_sync, state_r.sample_pixel_clock);
        state_nxt.aclk = agree(state_r.aclk_sync, state_r.aclk);
        state_nxt.clamp = agree(state_r.clamp_sync, state_r.clamp);
        state_nxt.pd_pin = agree(state_r.pd_sync, state_r.pd_pin);
        state_nxt.oe_pin = agree(state_r.oe_sync, state_r.oe_pin);

        // register writes stay live during power down
        state_nxt.soft_reset = 1'b0;
        if (i_wr) begin
            unique case (i_addr)
                afe_ctl_pkg::ADDR_GAIN: state_nxt.gain = i_wdata;
                afe_ctl_pkg::ADDR_CONTROL: state_nxt.control = i_wdata;
                afe_ctl_pkg::ADDR_CAL: state_nxt.cal = i_wdata;
                afe_ctl_pkg::ADDR_COARSE_MAN: begin
                    if (state_r.cal[afe_ctl_pkg::CAL_MANUAL]) begin
                        state_nxt.coarse = i_wdata[8:0];
                    end
                end
                afe_ctl_pkg::ADDR_FINE_MAN: begin
                    if (state_r.cal[afe_ctl_pkg::CAL_MANUAL]) begin
                        state_nxt.fine = i_wdata;
                    end
                end
                afe_ctl_pkg::ADDR_RESET: state_nxt.soft_reset = i_wdata[0];
                default: ;
            endcase
        end

        // accumulator stepping; overflow re-centres fine and moves coarse
        if (i_cal_step_valid && !cal_hold && !state_r.cal[afe_ctl_pkg::CAL_MANUAL]) begin
            if (i_cal_step_up) begin
                if (state_r.fine == 10'h3ff) begin
                    state_nxt.fine = afe_ctl_pkg::FINE_RESET;
                    state_nxt.coarse = state_r.coarse + 9'h001;
                end else begin
                    state_nxt.fine = state_r.fine + 10'h001;
                end
            end else begin
                if (state_r.fine == 10'h000) begin
                    state_nxt.fine = afe_ctl_pkg::FINE_RESET;
                    state_nxt.coarse = state_r.coarse - 9'h001;
                end else begin
                    state_nxt.fine = state_r.fine - 10'h001;
                end
            end
        end

        state_nxt.rdata = 10'h000;
        if (i_rd) begin
            unique case (i_addr)
                afe_ctl_pkg::ADDR_GAIN: state_nxt.rdata = state_r.gain;
                afe_ctl_pkg::ADDR_CONTROL: state_nxt.rdata = state_r.control;
                afe_ctl_pkg::ADDR_CAL: state_nxt.rdata = state_r.cal;
                afe_ctl_pkg::ADDR_COARSE_MAN: state_nxt.rdata = {1'b0, state_r.coarse};
                afe_ctl_pkg::ADDR_FINE_MAN: state_nxt.rdata = state_r.fine;
                afe_ctl_pkg::ADDR_STATUS:
                    state_nxt.rdata = {5'h00, drive_on, state_r.aclk, cal_hold,
                                       state_r.pd_pin, power_down};
                default: state_nxt.rdata = 10'h000;
            endcase
        end

        // converter data pipeline advances on the sampling edge
        if (state_nxt.aclk != state_r.aclk &&
            state_nxt.aclk == state_r.control[afe_ctl_pkg::CTL_CONV_POL]) begin
            state_nxt.pipe = {state_r.pipe[afe_ctl_pkg::LATENCY_WHOLE-1:0],
                              {i_conv_data, i_conv_over}};
        end
        // the extra half cycle: release on the opposite edge
        if (state_nxt.aclk != state_r.aclk &&
            state_nxt.aclk != state_r.control[afe_ctl_pkg::CTL_CONV_POL]) begin
            state_nxt.out = state_r.pipe[afe_ctl_pkg::LATENCY_WHOLE];
        end
    end

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    assign power_down = state_r.pd_pin || state_r.control[afe_ctl_pkg::CTL_POWER_DOWN];
    assign cal_hold = state_r.cal[afe_ctl_pkg::CAL_HOLD] || power_down;
    // drivers and the status read only; nothing else looks at this
    assign drive_on = state_r.control[afe_ctl_pkg::CTL_OUT_EN] && state_r.oe_pin
                      && !power_down;

    always_comb begin
        o_phase.black_phase = state_r.sample_black_clock;
        o_phase.pixel_phase = state_r.sample_pixel_clock;
        o_phase.reset_reject = !state_r.sample_black_clock && !state_r.sample_pixel_clock;
        o_phase.dc_restore = state_r.clamp && state_r.sample_pixel_clock;
    end

    logic direct_amp;
    logic direct_conv;
    assign direct_amp = state_r.control[afe_ctl_pkg::CTL_DIRECT_AMP];
    assign direct_conv = state_r.control[afe_ctl_pkg::CTL_DIRECT_CONV];

    always_comb begin
        o_analog.analog_on = !power_down;
        o_analog.dac1_on = !power_down && !state_r.control[afe_ctl_pkg::CTL_DAC1_OFF];
        o_analog.dac0_on = !power_down && !state_r.control[afe_ctl_pkg::CTL_DAC0_OFF];
        o_analog.front_end_on = !power_down && !direct_conv
                                && !state_r.control[afe_ctl_pkg::CTL_FRONT_END_OFF];
        o_analog.converter_on = !power_down
                                && !state_r.control[afe_ctl_pkg::CTL_CONV_OFF];
        o_analog.sampler_to_amp = !direct_amp && !direct_conv;
        o_analog.aux_to_amp = direct_amp && !direct_conv;
        o_analog.coarse_to_amp = !direct_amp;
        o_analog.fine_to_amp = 1'b1;
        o_analog.direct_to_conv = direct_conv;
        o_analog.conv_track = state_r.aclk ^ state_r.control[afe_ctl_pkg::CTL_CONV_POL];
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_rdata = state_r.rdata;
    assign o_gain_db_x768 = gain_scaled(state_r.gain);
    assign o_coarse_code = state_r.coarse;
    assign o_fine_code = state_r.fine;
    assign o_output_bus = state_r.out[12:1];
    assign o_range_exceeded_flag = state_r.out[0];
    assign o_output_bus_oe = {12{drive_on}};
    assign o_range_exceeded_oe = drive_on;

    // ------------------------------------------------------------
    // register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge chip_rst_n) begin
        if (!chip_rst_n) begin
            state_r <= '0;
            state_r.gain <= afe_ctl_pkg::GAIN_RESET;
            state_r.control <= afe_ctl_pkg::CONTROL_RESET;
            state_r.cal <= afe_ctl_pkg::CAL_RESET;
            state_r.coarse <= afe_ctl_pkg::COARSE_RESET;
            state_r.fine <= afe_ctl_pkg::FINE_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

endmodule // afe_ctl

// [hw/afe_ctl_pkg.sv]
// package for the front-end mode control block
// assumes a 25 MHz system clock and a plain register port
package afe_ctl_pkg;

    // register indices (word addressed, index = address)
    localparam logic [5:0] ADDR_GAIN = 6'h00;
    localparam logic [5:0] ADDR_CONTROL = 6'h08;
    localparam logic [5:0] ADDR_CAL = 6'h02;
    localparam logic [5:0] ADDR_FINE_MAN = 6'h07;
    localparam logic [5:0] ADDR_COARSE_MAN = 6'h06;
    localparam logic [5:0] ADDR_STATUS = 6'h20;
    localparam logic [5:0] ADDR_RESET = 6'h3f;

    // control register fields
    localparam int CTL_DIRECT_AMP = 0;
    localparam int CTL_DIRECT_CONV = 1;
    localparam int CTL_CONV_POL = 2;
    localparam int CTL_OUT_EN = 3;
    localparam int CTL_POWER_DOWN = 4;
    localparam int CTL_DAC1_OFF = 5;
    localparam int CTL_DAC0_OFF = 6;
    localparam int CTL_FRONT_END_OFF = 7;
    localparam int CTL_CONV_OFF = 8;
    localparam logic [9:0] CONTROL_RESET = 10'h008;

    // calibration register fields
    localparam int CAL_HOLD = 0;
    localparam int CAL_MANUAL = 1;
    localparam logic [9:0] CAL_RESET = 10'h000;
    localparam logic [9:0] GAIN_RESET = 10'h000;

    // gain mapping
    localparam logic [9:0] GAIN_SAT_CODE = 10'h300;
    // 36 dB at twelve output units per dB
    localparam logic [9:0] GAIN_MAX_DB = 10'h1b0;

    // accumulator widths and mid-scale values
    localparam logic [8:0] COARSE_RESET = 9'h100;
    localparam logic [9:0] FINE_RESET = 10'h200;

    // converter latency: 6.5 cycles -> 13 half cycles
    localparam int LATENCY_HALF_CYCLES = 13;
    localparam int LATENCY_WHOLE = LATENCY_HALF_CYCLES / 2;

    // register reset self clear: about 10 ns, at least one cycle
    localparam int CLK_PERIOD_NS = 40;
    localparam int SELF_CLEAR_NS = 10;
    localparam int SELF_CLEAR_CYCLES =
        (SELF_CLEAR_NS / CLK_PERIOD_NS) < 1 ? 1 : (SELF_CLEAR_NS / CLK_PERIOD_NS);

    typedef struct packed {
        logic black_phase;
        logic pixel_phase;
        logic reset_reject;
        logic dc_restore;
    } phase_t;

    typedef struct packed {
        logic analog_on;
        logic dac1_on;
        logic dac0_on;
        logic front_end_on;
        logic converter_on;
        logic sampler_to_amp;
        logic aux_to_amp;
        logic coarse_to_amp;
        logic fine_to_amp;
        logic direct_to_conv;
        logic conv_track;
    } analog_ctl_t;

    typedef struct packed {
        logic [11:0] data;
        logic over;
    } sample_t;

endpackage

// [dv/afe_ctl_chk.sv]
// port checker for afe_ctl
// bound to every afe_ctl instance; sees top-level ports only
`timescale 1ns/100ps
module afe_ctl_chk (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_reset_pin,
    input wire logic i_sample_black_clock,
    input wire logic i_sample_pixel_clock,
    input wire logic i_clamp,
    input wire logic i_power_down_pin,
    input wire logic i_output_drive_enable,
    input wire logic i_cal_step_valid,
    input wire logic [5:0] i_addr,
    input wire logic [9:0] i_wdata,
    input wire logic i_wr,
    input wire afe_ctl_pkg::phase_t o_phase,
    input wire afe_ctl_pkg::analog_ctl_t o_analog,
    input wire logic [9:0] o_gain_db_x768,
    input wire logic [8:0] o_coarse_code,
    input wire logic [9:0] o_fine_code,
    input wire logic [11:0] o_output_bus_oe,
    input wire logic o_range_exceeded_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    logic wr_rst;
    logic wr_gain;
    assign wr_rst = i_wr && !i_reset_pin && i_addr == afe_ctl_pkg::ADDR_RESET && i_wdata[0];
    assign wr_gain = i_wr && !i_reset_pin && i_addr == afe_ctl_pkg::ADDR_GAIN;
    a_dc_restore: assert property (o_phase.dc_restore |-> o_phase.pixel_phase)
        else $error("dc restore closed outside pixel phase");
    a_black_phase: assert property (i_sample_black_clock[*5] |-> o_phase.black_phase)
        else $error("black phase strobe missing");
    a_pixel_phase: assert property (i_sample_pixel_clock[*5] |-> o_phase.pixel_phase)
        else $error("pixel phase strobe missing");
    a_reset_reject: assert property ((!i_sample_black_clock && !i_sample_pixel_clock)[*5]
        |-> o_phase.reset_reject) else $error("reset reject strobe missing");
    a_dc_on: assert property ((i_clamp && i_sample_pixel_clock)[*5]
        |-> o_phase.dc_restore) else $error("dc restore not closed");
    a_dc_off: assert property ((!i_clamp)[*5] |-> !o_phase.dc_restore)
        else $error("dc restore closed without clamp");
    a_gain_sat: assert property (wr_gain && i_wdata >= afe_ctl_pkg::GAIN_SAT_CODE
        |=> o_gain_db_x768 == afe_ctl_pkg::GAIN_MAX_DB) else $error("gain not saturated");
    a_oe_whole: assert property (o_output_bus_oe == {12{o_range_exceeded_oe}})
        else $error("output enables disagree");
    a_oe_pin_low: assert property ((!i_output_drive_enable)[*6] |-> !o_range_exceeded_oe)
        else $error("drivers on with enable pin low");
    a_pd_pin: assert property (i_power_down_pin[*6]
        |-> !o_analog.analog_on && !o_range_exceeded_oe) else $error("power down pin ignored");
    a_aux_route: assert property (o_analog.aux_to_amp
        |-> !o_analog.sampler_to_amp && !o_analog.coarse_to_amp) else $error("aux route clash");
    a_fine_kept: assert property (o_analog.aux_to_amp && o_analog.analog_on
        |-> o_analog.fine_to_amp) else $error("fine dac dropped");
    a_direct_conv: assert property (o_analog.direct_to_conv |-> !o_analog.sampler_to_amp)
        else $error("sampler on in direct converter mode");
    a_pd_hold: assert property (!o_analog.analog_on && i_cal_step_valid && !i_wr
        && !i_reset_pin |-> ##2 o_fine_code == $past(o_fine_code, 2))
        else $error("accumulator moved in power down");
    a_soft_rst: assert property (wr_rst |-> ##4 o_fine_code == afe_ctl_pkg::FINE_RESET
        && o_coarse_code == afe_ctl_pkg::COARSE_RESET) else $error("register reset missing");
    a_pin_rst: assert property (i_reset_pin[*3] |-> o_fine_code == afe_ctl_pkg::FINE_RESET
        && !o_range_exceeded_oe) else $error("reset pin not holding");
    c_restore: cover property (o_phase.dc_restore);
    c_aux: cover property (o_analog.aux_to_amp);
    c_soft: cover property (wr_rst);
endmodule // afe_ctl_chk

bind afe_ctl afe_ctl_chk afe_ctl_chk_i (.i_clk, .i_arst_n, .i_reset_pin, .i_power_down_pin,
    .i_sample_black_clock, .i_sample_pixel_clock, .i_clamp,
    .i_output_drive_enable, .i_cal_step_valid, .i_addr, .i_wdata, .i_wr, .o_phase, .o_analog,
    .o_gain_db_x768, .o_coarse_code, .o_fine_code, .o_output_bus_oe, .o_range_exceeded_oe);

// [dv/afe_ctl_partner.sv]
// timing generator model: sample clocks, converter clock, clamp, raw result
// one converter period is 20 bench cycles; all clocks stand low when idle
`timescale 1ns/100ps
module afe_ctl_partner (
    input wire logic i_clk,
    input wire logic i_run,
    output logic o_black,
    output logic o_pixel,
    output logic o_conv_clk,
    output logic o_clamp,
    output afe_ctl_pkg::sample_t o_res
);
    logic [4:0] ph_r = 5'h00;
    logic [11:0] cnt_r = 12'h000;
    always_ff @(posedge i_clk) begin
        if (ph_r != 5'h00 || i_run) begin
            ph_r <= (ph_r == 5'h13) ? 5'h00 : ph_r + 5'h01;
        end
        if (ph_r == 5'h00 && i_run) begin
            cnt_r <= cnt_r + 12'h001;
        end
    end
    // black phase ends with the converter high half
    assign o_conv_clk = ph_r >= 5'h01 && ph_r <= 5'h0a;
    assign o_black = ph_r >= 5'h06 && ph_r <= 5'h0a;
    assign o_pixel = ph_r >= 5'h0e && ph_r <= 5'h12;
    assign o_clamp = cnt_r[2];
    // idle data lines show no stale value; over keeps cnt_r[0]
    assign o_res = '{data: (ph_r == 5'h00) ? ~cnt_r : cnt_r, over: cnt_r[0]};
endmodule // afe_ctl_partner

// [dv/afe_ctl_tb_top.sv]
// self-checking bench for afe_ctl with the timing generator model
// one 25 MHz clock; register port driven by tasks
`timescale 1ns/100ps
module afe_ctl_tb_top;
    logic i_clk = 1'b0, i_arst_n = 1'b0, i_reset_pin = 1'b0, i_power_down_pin = 1'b0;
    logic i_output_drive_enable = 1'b1, i_cal_step_valid = 1'b0, i_cal_step_up = 1'b0;
    logic i_wr = 1'b0, i_rd = 1'b0, run = 1'b0, rd_seen = 1'b0, cc_d = 1'b0, streaming = 1'b0;
    logic [5:0] i_addr = 6'h00;
    logic [9:0] i_wdata = 10'h000, code, o_rdata, o_gain_db_x768, o_fine_code;
    logic [8:0] o_coarse_code;
    logic [11:0] o_output_bus, o_output_bus_oe, bus_d = 12'h000;
    logic black, pixel, conv_clk, clamp, o_range_exceeded_flag, o_range_exceeded_oe;
    afe_ctl_pkg::sample_t res;
    afe_ctl_pkg::sample_t sq[$];
    afe_ctl_pkg::phase_t o_phase;
    afe_ctl_pkg::analog_ctl_t o_analog;
    logic [15:0] rq[$];
    logic [9:0] codes[4] = '{10'h000, 10'h2ff, 10'h300, 10'h3ff};
    int iq[$];
    int miscompares = 0, tests_run = 0, falls = 0;
    always #20 i_clk = ~i_clk;
    afe_ctl afe_ctl_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_reset_pin(i_reset_pin),
        .i_sample_black_clock(black), .i_sample_pixel_clock(pixel), .i_converter_clock(conv_clk),
        .i_clamp(clamp), .i_power_down_pin(i_power_down_pin),
        .i_output_drive_enable(i_output_drive_enable), .i_conv_data(res.data),
        .i_conv_over(res.over), .i_cal_step_valid(i_cal_step_valid), .i_cal_step_up(i_cal_step_up),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_phase(o_phase), .o_analog(o_analog), .o_gain_db_x768(o_gain_db_x768),
        .o_coarse_code(o_coarse_code), .o_fine_code(o_fine_code), .o_output_bus(o_output_bus),
        .o_output_bus_oe(o_output_bus_oe), .o_range_exceeded_flag(o_range_exceeded_flag),
        .o_range_exceeded_oe(o_range_exceeded_oe));
    afe_ctl_partner afe_ctl_partner_i (.i_clk(i_clk), .i_run(run), .o_black(black),
        .o_pixel(pixel), .o_conv_clk(conv_clk), .o_clamp(clamp), .o_res(res));
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [9:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        cyc(1);
        i_wr <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [5:0] a, input logic [9:0] e);
        rq.push_back({6'h00, e});
        i_addr <= a;
        i_rd <= 1'b1;
        cyc(1);
        i_rd <= 1'b0;
        cyc(1);
    endtask
    task automatic step();
        i_cal_step_up <= 1'b1;
        i_cal_step_valid <= 1'b1;
        cyc(1);
        i_cal_step_valid <= 1'b0;
        cyc(4);
    endtask
    always @(posedge i_clk) rd_seen <= i_rd;
    // result watcher: reads, sampling edges and output bus changes
    always @(negedge i_clk) begin
        if (rd_seen) begin
            cmp("rdata", rq.pop_front(), {6'h00, o_rdata});
        end
        if (streaming && cc_d && !conv_clk) begin
            falls++;
            sq.push_back(res);
            iq.push_back(falls);
        end
        cc_d = conv_clk;
        if (streaming && o_output_bus !== bus_d && sq.size() > 0) begin
            cmp("bus", {3'h0, sq.pop_front()}, {3'h0, o_output_bus, o_range_exceeded_flag});
            cmp("latency", 16'h0006, 16'(falls - iq.pop_front()));
        end
        bus_d = o_output_bus;
    end
    initial begin
        cyc(60000);
        miscompares++;
        give_verdict();
    end
    initial begin
        void'($urandom(2157));
        cyc(4);
        i_arst_n <= 1'b1;
        cyc(4);
        rd(afe_ctl_pkg::ADDR_CONTROL, afe_ctl_pkg::CONTROL_RESET);
        rd(afe_ctl_pkg::ADDR_CAL, afe_ctl_pkg::CAL_RESET);
        rd(6'h15, 10'h000);
        cmp("acc", 16'h0300, {6'h00, o_coarse_code} + {6'h00, o_fine_code});
        for (int k = 0; k < 8; k++) begin
            code = (k < 4) ? codes[k] : 10'($urandom_range(1023));
            wr(afe_ctl_pkg::ADDR_GAIN, code);
            cmp("gain", (code >= afe_ctl_pkg::GAIN_SAT_CODE) ? {6'h00, afe_ctl_pkg::GAIN_MAX_DB}
                : 16'((code * 36) / 64), {6'h00, o_gain_db_x768});
        end
        streaming = 1'b1;
        run <= 1'b1;
        cyc(600);
        run <= 1'b0;
        cyc(60);
        cmp("pending", 16'h0007, 16'(sq.size()));
        streaming = 1'b0;
        i_output_drive_enable <= 1'b0;
        cyc(8);
        cmp("oe", 16'h0000, {3'h0, o_output_bus_oe, o_range_exceeded_oe});
        step();
        cmp("fine", 16'h0201, {6'h00, o_fine_code});
        i_output_drive_enable <= 1'b1;
        wr(afe_ctl_pkg::ADDR_CAL, 10'h001);
        step();
        cmp("fine", 16'h0201, {6'h00, o_fine_code});
        wr(afe_ctl_pkg::ADDR_CONTROL, 10'h009);
        cmp("amp", 16'h0005, {12'h000, o_analog[5:4], o_analog[3:2]});
        wr(afe_ctl_pkg::ADDR_CONTROL, 10'h00a);
        cmp("conv", 16'h0001, {14'h0000, o_analog.sampler_to_amp, o_analog.direct_to_conv});
        for (int p = 0; p < 2; p++) begin
            wr(afe_ctl_pkg::ADDR_CONTROL, 10'h008 | (10'(p) << 2));
            cmp("track", 16'(p), {15'h0000, o_analog.conv_track});
        end
        for (int b = 5; b < 9; b++) begin
            wr(afe_ctl_pkg::ADDR_CONTROL, afe_ctl_pkg::CONTROL_RESET | (10'h001 << b));
            cmp("part", 16'(5'h1f ^ (5'h01 << (8 - b))), {11'h000, o_analog[10:6]});
        end
        wr(afe_ctl_pkg::ADDR_CAL, 10'h002);
        wr(afe_ctl_pkg::ADDR_FINE_MAN, 10'h155);
        cmp("manual", 16'h0155, {6'h00, o_fine_code});
        wr(afe_ctl_pkg::ADDR_CAL, 10'h000);
        wr(afe_ctl_pkg::ADDR_CONTROL, 10'h018);
        cmp("pd", 16'h0000, {14'h0000, o_analog.analog_on, o_range_exceeded_oe});
        step();
        cmp("fine", 16'h0155, {6'h00, o_fine_code});
        rd(afe_ctl_pkg::ADDR_STATUS, 10'h005);
        rd(afe_ctl_pkg::ADDR_CONTROL, 10'h018);
        rd(afe_ctl_pkg::ADDR_GAIN, code);
        wr(afe_ctl_pkg::ADDR_CONTROL, 10'h008);
        i_power_down_pin <= 1'b1;
        cyc(8);
        cmp("pdpin", 16'h0000, {15'h0000, o_analog.analog_on});
        i_power_down_pin <= 1'b0;
        cyc(8);
        cmp("oe", 16'h1fff, {3'h0, o_output_bus_oe, o_range_exceeded_oe});
        wr(afe_ctl_pkg::ADDR_RESET, 10'h001);
        cyc(10);
        rd(afe_ctl_pkg::ADDR_RESET, 10'h000);
        rd(afe_ctl_pkg::ADDR_GAIN, afe_ctl_pkg::GAIN_RESET);
        cmp("fine", {6'h00, afe_ctl_pkg::FINE_RESET}, {6'h00, o_fine_code});
        wr(afe_ctl_pkg::ADDR_GAIN, 10'h0aa);
        i_reset_pin <= 1'b1;
        cyc(5);
        i_reset_pin <= 1'b0;
        cyc(8);
        rd(afe_ctl_pkg::ADDR_GAIN, afe_ctl_pkg::GAIN_RESET);
        cyc(2);
        give_verdict();
    end
endmodule // afe_ctl_tb_top
